// ---- sacp_conversion_port.sv ----
// Sequencer and serial output of the 10-bit successive-approximation port.
//
// Behaviour
// - Select low starts a transaction.
// - Select high aborts conversion, enters standby.
// - Sample over 1.5 clocks from first rise.
// - Hold sample, deliver 10-bit serial code.
// - One result bit resolved per clock.
// - Output changes only on falling clock edges, or when select goes high.
// - Input at or below zero gives zero.
// - Input at reference minus LSB gives ones.
// - Code equals input times 1024 over reference.
// - Null bit, then ten bits MSB first.
// - Further clocks resend LSB first, then zeros.
// - Powered with select low needs re-toggle.
// - Output high impedance for first two clocks.
`timescale 1ns/1ps
`include "sacp_defines.svh"
`default_nettype none

module sacp_conversion_port
   import sacp_pkg::*;
(
   input  wire logic                             ref_clk,
   input  wire logic                             rst,
   input  wire logic                             sclk,
   input  wire logic                             select_shutdown_n,
   input  wire logic signed [`SACP_IN_BITS-1:0]  vin_diff,
   input  wire logic [`SACP_IN_BITS-1:0]         vref,
   output logic                                  sdo_out,
   output logic                                  sdo_oe,
   output logic                                  standby
);

   // -----------------------------------------------------------------
   // Pin synchronisers
   // -----------------------------------------------------------------
   // Both pins come from the host's domain. A level is accepted only
   // once the second and third stages agree, which filters a single
   // metastable sample at the cost of one cycle of latency.
   sacp_pins_t [`SACP_SYNC_DEPTH-1:0] sync_ff;
   sacp_pins_t [`SACP_SYNC_DEPTH-1:0] nxt_sync;
   sacp_pins_t                        lvl_ff;
   sacp_pins_t                        nxt_lvl;

   always_comb
   begin
      nxt_sync[0]       = '{sclk: sclk, sel_n: select_shutdown_n};
      nxt_sync[1]       = sync_ff[0];
      nxt_sync[2]       = sync_ff[1];
      nxt_lvl           = lvl_ff;
      if (sync_ff[1].sclk == sync_ff[2].sclk)
      begin
         nxt_lvl.sclk = sync_ff[2].sclk;
      end
      if (sync_ff[1].sel_n == sync_ff[2].sel_n)
      begin
         nxt_lvl.sel_n = sync_ff[2].sel_n;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         // Select is taken as low out of reset. A pin already low at
         // power-up then never looks like a fresh fall; the port arms
         // only once it has really seen the pin high.
         sync_ff <= '{default: '{sclk: 1'b0, sel_n: 1'b0}};
         lvl_ff  <= '{sclk: 1'b0, sel_n: 1'b0};
      end
      else
      begin
         sync_ff <= nxt_sync;
         lvl_ff  <= nxt_lvl;
      end
   end

   logic sclk_rise;
   logic sclk_fall;
   assign sclk_rise = nxt_lvl.sclk & ~lvl_ff.sclk;
   assign sclk_fall = ~nxt_lvl.sclk & lvl_ff.sclk;

   // -----------------------------------------------------------------
   // Successive-approximation comparator
   // -----------------------------------------------------------------
   logic [`SACP_IN_BITS-1:0]                   held_ff;
   logic [`SACP_IN_BITS-1:0]                   nxt_held;
   logic [`SACP_IN_BITS-1:0]                   vin_mag;
   logic [`SACP_RES_BITS-1:0]                  code_ff;
   logic [`SACP_RES_BITS-1:0]                  nxt_code;
   logic [`SACP_RES_BITS-1:0]                  trial;
   logic [`SACP_IN_BITS+`SACP_RES_BITS-1:0]    scaled_in;
   logic [`SACP_IN_BITS+`SACP_RES_BITS-1:0]    trial_ref;
   logic                                       trial_ok;

   // A negative difference clamps to zero magnitude.
   assign vin_mag   = vin_diff[`SACP_IN_BITS-1] ? '0 : vin_diff;
   // Trial level times reference against input times 1024.
   assign scaled_in = {held_ff, {`SACP_LSB_SHIFT{1'b0}}};
   assign trial_ref = trial * vref;
   assign trial_ok  = (scaled_in >= trial_ref);

   // -----------------------------------------------------------------
   // Transaction sequencer
   // -----------------------------------------------------------------
   sacp_state_t               state_ff;
   sacp_state_t               nxt_state;
   logic [`SACP_EDGE_W-1:0]   fall_ff;
   logic [`SACP_EDGE_W-1:0]   nxt_fall;
   logic [3:0]                bit_ff;
   logic [3:0]                nxt_bit;
   logic                      armed_ff;
   logic                      nxt_armed;
   sacp_sdo_t                 sdo_ff;
   sacp_sdo_t                 nxt_sdo;

   always_comb
   begin
      nxt_state = state_ff;
      nxt_fall  = fall_ff;
      nxt_bit   = bit_ff;
      nxt_armed = armed_ff;
      nxt_sdo   = sdo_ff;
      nxt_held  = held_ff;
      nxt_code  = code_ff;
      trial     = code_ff | (`SACP_RES_BITS'(1) << bit_ff);
      if (nxt_lvl.sel_n)
      begin
         // Select high ends any conversion and releases the line.
         nxt_state = SACP_IDLE;
         nxt_sdo   = '{data: 1'b0, oe: 1'b0};
         nxt_armed = 1'b1;
         nxt_fall  = '0;
      end
      else
      begin
         case (state_ff)
            SACP_IDLE:
            begin
               // Only a fresh falling select edge may start.
               if (armed_ff)
               begin
                  nxt_state = SACP_SAMPLE;
                  nxt_armed = 1'b0;
                  nxt_fall  = '0;
                  nxt_code  = `SACP_CODE_ZERO;
               end
            end
            SACP_SAMPLE:
            begin
               // Track the input from the first rise to the second fall.
               if (sclk_rise)
               begin
                  nxt_held = vin_mag;
               end
               if (sclk_fall)
               begin
                  nxt_fall = fall_ff + `SACP_EDGE_W'(1);
                  if (nxt_fall == `SACP_FALL_NULL)
                  begin
                     // Switch opens; null bit drives low.
                     nxt_held  = vin_mag;
                     nxt_sdo   = '{data: 1'b0, oe: 1'b1};
                     nxt_bit   = 4'(`SACP_RES_BITS - 1);
                     nxt_state = SACP_MSB_OUT;
                  end
               end
            end
            SACP_MSB_OUT:
            begin
               if (sclk_fall)
               begin
                  // One decision per falling edge, shown at once.
                  nxt_fall = fall_ff + `SACP_EDGE_W'(1);
                  if (trial_ok)
                  begin
                     nxt_code = trial;
                  end
                  nxt_sdo.data = trial_ok;
                  if (bit_ff == 4'h0)
                  begin
                     nxt_bit   = 4'h1;
                     nxt_state = SACP_LSB_OUT;
                  end
                  else
                  begin
                     nxt_bit = bit_ff - 4'h1;
                  end
               end
            end
            SACP_LSB_OUT:
            begin
               // The LSB was the last MSB-first bit, so repeat from B1.
               if (sclk_fall)
               begin
                  nxt_fall     = fall_ff + `SACP_EDGE_W'(1);
                  nxt_sdo.data = code_ff[bit_ff];
                  if (nxt_fall == `SACP_FALL_ZERO - `SACP_EDGE_W'(1))
                  begin
                     nxt_state = SACP_ZERO_OUT;
                  end
                  else
                  begin
                     nxt_bit = bit_ff + 4'h1;
                  end
               end
            end
            SACP_ZERO_OUT:
            begin
               if (sclk_fall)
               begin
                  nxt_sdo.data = 1'b0;
               end
            end
            default:
            begin
               nxt_state = SACP_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         state_ff <= SACP_IDLE;
         fall_ff  <= '0;
         bit_ff   <= 4'h0;
         armed_ff <= 1'b0;
         sdo_ff   <= '{data: 1'b0, oe: 1'b0};
         held_ff  <= '0;
         code_ff  <= `SACP_CODE_ZERO;
      end
      else
      begin
         state_ff <= nxt_state;
         fall_ff  <= nxt_fall;
         bit_ff   <= nxt_bit;
         armed_ff <= nxt_armed;
         sdo_ff   <= nxt_sdo;
         held_ff  <= nxt_held;
         code_ff  <= nxt_code;
      end
   end

   assign sdo_out = sdo_ff.data;
   assign sdo_oe  = sdo_ff.oe;
   assign standby = (state_ff == SACP_IDLE);

endmodule // sacp_conversion_port
`default_nettype wire

// ---- sacp_defines.svh ----
// Constants for the serial converter port: widths, codes and timing.
`ifndef SACP_DEFINES_SVH
`define SACP_DEFINES_SVH

`define SACP_RES_BITS     10
`define SACP_IN_BITS      16
`define SACP_CODE_ZERO    10'h000
`define SACP_CODE_FULL    10'h3ff
`define SACP_LSB_SHIFT    10
`define SACP_EDGE_W       5
`define SACP_FALL_NULL    5'h02
`define SACP_FALL_LSB     5'h0d
`define SACP_FALL_ZERO    5'h16
`define SACP_SYNC_DEPTH   3
`define SACP_CLK_HZ       20000000
`define SACP_MIN_SCLK_HZ  10000

`endif

// ---- sacp_host_model.sv ----
// Host model: drives select and serial clock, samples data on rises.
`timescale 1ns/1ps
`default_nettype none
module sacp_host_model
(
   input  wire logic ref_clk,
   input  wire logic sdo_w,
   output var  logic sclk,
   output var  logic sel_n
);
   // --------
   // Drivers
   // --------
   // Powering up with select low exercises the re-arm behaviour.
   initial sel_n = 1'b0;
   initial sclk = 1'b0;
   task automatic sel(input logic lvl);
      repeat (6) @(posedge ref_clk);
      sel_n <= lvl;
      repeat (6) @(posedge ref_clk);
      #1;
   endtask
   // Mode 0,0; six-cycle phases stay above the 250 ns the port needs.
   // A 600 ns bit period also keeps the held sample from decaying.
   task automatic run(input int n, output logic [23:0] cap);
      cap = 'x;
      for (int i = 0; i < n; i++)
      begin
         repeat (6) @(posedge ref_clk);
         cap[i] = sdo_w;
         sclk <= 1'b1;
         repeat (6) @(posedge ref_clk);
         sclk <= 1'b0;
      end
   endtask
endmodule // sacp_host_model
`default_nettype wire

// ---- sacp_pkg.sv ----
// Types shared by the serial converter port.
`default_nettype none
package sacp_pkg;

   typedef enum logic [2:0] {
      SACP_IDLE,
      SACP_SAMPLE,
      SACP_MSB_OUT,
      SACP_LSB_OUT,
      SACP_ZERO_OUT
   } sacp_state_t;

   typedef struct packed {
      logic data;
      logic oe;
   } sacp_sdo_t;

   typedef struct packed {
      logic sclk;
      logic sel_n;
   } sacp_pins_t;

endpackage
`default_nettype wire

// ---- sacp_port_asserts.sv ----
// Pin-level checks on the serial converter port.
`timescale 1ns/1ps
`default_nettype none
module sacp_port_asserts
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic sclk,
   input wire logic select_shutdown_n,
   input wire logic sdo_out,
   input wire logic sdo_oe,
   input wire logic standby
);
   // -------
   // Checks
   // -------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Six cycles covers the three-stage synchroniser plus one register.
   a_sel_high_oe: assert property
      (select_shutdown_n [*6] |-> !sdo_oe)
      else $error("output enabled with select high");
   a_sel_high_stby: assert property
      (select_shutdown_n [*6] |-> standby)
      else $error("not in standby with select high");
   // The host holds the clock high for six samples, so a run of five
   // occurs twice per high phase and reaches past where a rise shows.
   a_edge_only_fall: assert property
      ((sclk && !select_shutdown_n) [*5] |-> $stable(sdo_out))
      else $error("data changed away from a falling clock");
   a_oe_rise_low: assert property
      ($rose(sdo_oe) |-> !sclk && !select_shutdown_n)
      else $error("output enabled outside a falling edge");
   a_null_first: assert property ($rose(sdo_oe) |-> !sdo_out)
      else $error("first driven bit not low");
   a_oe_needs_sel: assert property
      (sdo_oe |-> !$past(select_shutdown_n, 7))
      else $error("output still enabled after select rose");
   a_oe_off_zero: assert property (!sdo_oe |-> !sdo_out)
      else $error("data high while released");
   a_stby_vs_oe: assert property (sdo_oe |-> !standby)
      else $error("driving while in standby");
   a_start_fall: assert property
      ($fell(standby) |-> !select_shutdown_n)
      else $error("left standby without select low");
   c_oe: cover property ($rose(sdo_oe));
   c_start: cover property ($fell(standby));
   c_abort: cover property ($rose(select_shutdown_n) && sdo_oe);
endmodule // sacp_port_asserts
bind sacp_conversion_port sacp_port_asserts u_chk
(
   .ref_clk(ref_clk),
   .rst(rst),
   .sclk(sclk),
   .select_shutdown_n(select_shutdown_n),
   .sdo_out(sdo_out),
   .sdo_oe(sdo_oe),
   .standby(standby)
);
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the serial converter port.
`timescale 1ns/1ps
`include "sacp_defines.svh"
`default_nettype none
module tb;
   logic                           ref_clk;
   logic                           rst;
   logic signed [`SACP_IN_BITS-1:0] vin_diff;
   logic [`SACP_IN_BITS-1:0]       vref;
   logic                           sclk;
   logic                           sel_n;
   logic                           sdo_out;
   logic                           sdo_oe;
   logic                           standby;
   logic [23:0]                    cap;
   int                             n_errors = 0;
   int                             cmp_count = 0;
   int                             cycles = 0;
   wire sdo_w = sdo_oe ? sdo_out : 1'bz;
   sacp_conversion_port uut (.ref_clk(ref_clk), .rst(rst), .sclk(sclk),
      .select_shutdown_n(sel_n), .vin_diff(vin_diff), .vref(vref),
      .sdo_out(sdo_out), .sdo_oe(sdo_oe), .standby(standby));
   sacp_host_model host (.ref_clk(ref_clk), .sdo_w(sdo_w), .sclk(sclk),
      .sel_n(sel_n));
   // ----------
   // Utilities
   // ----------
   task automatic test_done();
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic exp, input logic got);
      cmp_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] %s exp %b got %b", what, exp, got);
      end
   endtask
   function automatic logic [9:0] exp_code(input int v, input int r);
      if (v <= 0)
         return `SACP_CODE_ZERO;
      if (v * 1024 / r > 1023)
         return `SACP_CODE_FULL;
      return 10'(v * 1024 / r);
   endfunction
   // ----------
   // Scenarios
   // ----------
   task automatic t_powerup();
      host.run(3, cap);
      chk("oe", 1'b0, sdo_oe);
      chk("standby", 1'b1, standby);
      host.sel(1'b1);
   endtask
   // Select rising in mid-frame must drop the output and idle the port.
   task automatic t_abort();
      host.sel(1'b0);
      host.run(6, cap);
      chk("oe", 1'b1, sdo_oe);
      host.sel(1'b1);
      chk("oe", 1'b0, sdo_oe);
      chk("standby", 1'b1, standby);
   endtask
   // Input moves after the second clock must not reach the code, since
   // the sample is already held by then.
   task automatic t_hold();
      logic [23:0] head;
      logic [9:0]  c;
      c = exp_code(333, 1000);
      @(posedge ref_clk);
      vin_diff <= 16'(333);
      vref <= 16'(1000);
      host.sel(1'b0);
      host.run(3, head);
      vin_diff <= 16'(900);
      host.run(10, cap);
      host.sel(1'b1);
      chk("null", 1'b0, head[2]);
      for (int i = 0; i < 10; i++)
         chk("held", c[9-i], cap[i]);
   endtask
   task automatic t_codes();
      int tv[5] = '{0, -5, 1023, 2000, 333};
      int tr[5] = '{1000, 1000, 1024, 1024, 1000};
      logic [9:0] c;
      for (int k = 0; k < 5; k++)
      begin
         @(posedge ref_clk);
         vin_diff <= 16'(tv[k]);
         vref <= 16'(tr[k]);
         c = exp_code(tv[k], tr[k]);
         host.sel(1'b0);
         host.run(24, cap);
         chk("standby", 1'b0, standby);
         host.sel(1'b1);
         for (int i = 0; i < 2; i++)
            chk("hiz", 1'bz, cap[i]);
         chk("null", 1'b0, cap[2]);
         for (int i = 0; i < 10; i++)
            chk("msb", c[9-i], cap[3+i]);
         for (int i = 1; i < 10; i++)
            chk("lsb", c[i], cap[12+i]);
         chk("zero", 1'b0, cap[22]);
         chk("zero", 1'b0, cap[23]);
      end
   endtask
   // -----
   // Main
   // -----
   initial
   begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         n_errors++;
         test_done();
      end
   end
   initial
   begin
      rst = 1'b1;
      vin_diff = '0;
      vref = 16'h0400;
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      t_powerup();
      t_abort();
      t_hold();
      t_codes();
      test_done();
   end
endmodule // tb
`default_nettype wire
